// ### core/ctmr_top.sv
// compact timer core with AXI4-Lite register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module ctmr_top
  import ctmr_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic EXT_COUNT_PIN,
  input wire logic SUB_CLOCK,
  output logic TIMER_OUT,
  output logic TIMER_OUT_USED,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  logic rst_s1_reg, rst_n_reg;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic sub_s1_reg, sub_s2_reg, sub_s3_reg;
  logic [5:0] psc_reg;
  logic aw_full_reg, w_full_reg, w_strb_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg, w_data_reg, rd_addr_reg, cmp_p_reg, buf_reg, rd_byte;
  logic [1:0] bresp_reg, rresp_reg, io_reg;
  logic [31:0] rdata_reg;
  logic pause_reg, on_reg, on_prev_reg, oc_reg, pol_reg, dpx_reg, cclr_reg;
  ctmr_cksel_t cksel_reg;
  ctmr_mode_t mode_reg;
  logic [15:0] cmp_a_reg, cnt_reg, cnt_next, cnt_inc;
  logic out_reg, out_next, flag_a_reg, flag_p_reg, pin_reg;
  logic wr_fire, rd_fire, wr_ok, rd_hit, on_rise, tick_sel, tick_ok;
  logic match_a, match_p, clr_by_a, clear_now, pwm_on, level_c, pin_used;
  logic [16:0] duty_val;

  // reset release through two flops
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      {rst_s1_reg, rst_n_reg} <= 2'h0;
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // pin and sub clock synchronisers; stage 3 only feeds edge detection
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      {ext_s3_reg, ext_s2_reg, ext_s1_reg} <= 3'h0;
      {sub_s3_reg, sub_s2_reg, sub_s1_reg} <= 3'h0;
    end
    else
    begin
      {ext_s3_reg, ext_s2_reg, ext_s1_reg} <= {ext_s2_reg, ext_s1_reg, EXT_COUNT_PIN};
      {sub_s3_reg, sub_s2_reg, sub_s1_reg} <= {sub_s2_reg, sub_s1_reg, SUB_CLOCK};
    end
  end

  // high clock taken as the system clock; one shared prescaler
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      psc_reg <= 6'h00;
    else
      psc_reg <= psc_reg + 6'h01;
  end

  always_comb
  begin
    case (cksel_reg)
      CTMR_CK_SYS4: tick_sel = &psc_reg[1:0];
      CTMR_CK_SYS: tick_sel = 1'b1;
      CTMR_CK_H16: tick_sel = &psc_reg[3:0];
      CTMR_CK_H64: tick_sel = &psc_reg;
      CTMR_CK_SUB0, CTMR_CK_SUB1: tick_sel = sub_s2_reg & ~sub_s3_reg;
      CTMR_CK_PINR: tick_sel = ext_s2_reg & ~ext_s3_reg;
      CTMR_CK_PINF: tick_sel = ~ext_s2_reg & ext_s3_reg;
      default: tick_sel = 1'b0;
    endcase
  end

  // AXI write side: address and data may arrive in either order
  assign AWREADY = ~aw_full_reg;
  assign WREADY = ~w_full_reg;
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_ok = wr_fire & w_strb_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      {aw_full_reg, w_full_reg, w_strb_reg, bvalid_reg} <= 4'h0;
      aw_addr_reg <= CTMR_RST_BYTE;
      w_data_reg <= CTMR_RST_BYTE;
      bresp_reg <= CTMR_RESP_OKAY;
    end
    else
    begin
      if (AWVALID && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end
      else if (wr_fire)
        aw_full_reg <= 1'b0;
      if (WVALID && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= WDATA[7:0];
        w_strb_reg <= WSTRB[0];
      end
      else if (wr_fire)
        w_full_reg <= 1'b0;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= CTMR_OFS_FLAGS
          && aw_addr_reg != CTMR_OFS_CNT_LO && aw_addr_reg != CTMR_OFS_CNT_HI)
          ? CTMR_RESP_OKAY : CTMR_RESP_SLVERR;
      end
      else if (BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // control and compare registers
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      {pause_reg, on_reg, oc_reg, pol_reg, dpx_reg, cclr_reg} <= 6'h00;
      cksel_reg <= CTMR_CK_SYS4;
      mode_reg <= CTMR_MODE_CMP;
      io_reg <= 2'h0;
      cmp_a_reg <= CTMR_RST_WORD;
      cmp_p_reg <= CTMR_RST_BYTE;
    end
    else if (wr_ok)
    begin
      case (aw_addr_reg)
        CTMR_OFS_CTRL_A:
        begin
          pause_reg <= w_data_reg[CTMR_POS_PAUSE];
          cksel_reg <= ctmr_cksel_t'(w_data_reg[CTMR_POS_CKSEL +: 3]);
          on_reg <= w_data_reg[CTMR_POS_ON];
        end
        CTMR_OFS_CTRL_B:
        begin
          mode_reg <= ctmr_mode_t'(w_data_reg[CTMR_POS_MODE +: 2]);
          io_reg <= w_data_reg[CTMR_POS_IO +: 2];
          oc_reg <= w_data_reg[CTMR_POS_OC];
          pol_reg <= w_data_reg[CTMR_POS_POL];
          dpx_reg <= w_data_reg[CTMR_POS_DPX];
          cclr_reg <= w_data_reg[CTMR_POS_CCLR];
        end
        CTMR_OFS_CMPA_HI: cmp_a_reg <= {w_data_reg, buf_reg};
        CTMR_OFS_CMPP: cmp_p_reg <= w_data_reg;
        default: ;
      endcase
    end
  end

  // shared low-byte buffer; a write lands here until the high byte goes
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      buf_reg <= CTMR_RST_BYTE;
    else if (wr_ok && aw_addr_reg == CTMR_OFS_CMPA_LO)
      buf_reg <= w_data_reg;
    else if (rd_fire && ARADDR == CTMR_OFS_CNT_HI)
      buf_reg <= cnt_reg[7:0];
    else if (rd_fire && ARADDR == CTMR_OFS_CMPA_HI)
      buf_reg <= cmp_a_reg[7:0];
  end

  // AXI read side
  assign ARREADY = ~rvalid_reg;
  assign rd_fire = ARVALID & ~rvalid_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;

  always_comb
  begin
    rd_hit = 1'b1;
    case (ARADDR)
      CTMR_OFS_CTRL_A: rd_byte = {pause_reg, cksel_reg, on_reg, 3'h0};
      CTMR_OFS_CTRL_B:
        rd_byte = {mode_reg, io_reg, oc_reg, pol_reg, dpx_reg, cclr_reg};
      CTMR_OFS_CNT_LO: rd_byte = buf_reg;
      CTMR_OFS_CNT_HI: rd_byte = cnt_reg[15:8];
      CTMR_OFS_CMPA_LO: rd_byte = buf_reg;
      CTMR_OFS_CMPA_HI: rd_byte = cmp_a_reg[15:8];
      CTMR_OFS_CMPP: rd_byte = cmp_p_reg;
      CTMR_OFS_FLAGS: rd_byte = {6'h00, flag_p_reg, flag_a_reg};
      default:
      begin
        rd_byte = CTMR_RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= CTMR_RESP_OKAY;
      rd_addr_reg <= CTMR_RST_BYTE;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_hit ? CTMR_RESP_OKAY : CTMR_RESP_SLVERR;
      rd_addr_reg <= ARADDR;
    end
    else if (RREADY)
      rvalid_reg <= 1'b0;
  end

  // counter and comparators
  assign on_rise = on_reg & ~on_prev_reg;
  assign tick_ok = on_reg & ~pause_reg & tick_sel;
  assign cnt_inc = cnt_reg + 16'h0001;
  assign clr_by_a = (mode_reg == CTMR_MODE_PWM) ? dpx_reg : cclr_reg;

  always_comb
  begin
    match_a = tick_ok && cmp_a_reg != CTMR_RST_WORD && cnt_inc == cmp_a_reg;
    if (cmp_p_reg == CTMR_RST_BYTE)
      match_p = tick_ok && cnt_reg == 16'hffff;
    else
      match_p = tick_ok && cnt_inc == {cmp_p_reg, 8'h00};
    clear_now = clr_by_a ? match_a : match_p;
    if (on_rise)
      cnt_next = CTMR_RST_WORD;
    else if (tick_ok)
      cnt_next = clear_now ? CTMR_RST_WORD : cnt_inc;
    else
      cnt_next = cnt_reg;
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      cnt_reg <= CTMR_RST_WORD;
      on_prev_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      on_prev_reg <= on_reg;
    end
  end

  // flags: a hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      {flag_a_reg, flag_p_reg} <= 2'h0;
    else
    begin
      if (match_a)
        flag_a_reg <= 1'b1;
      else if (wr_ok && aw_addr_reg == CTMR_OFS_FLAGS && w_data_reg[CTMR_POS_FLAG_A])
        flag_a_reg <= 1'b0;
      if (match_p && (mode_reg == CTMR_MODE_PWM || !cclr_reg))
        flag_p_reg <= 1'b1;
      else if (wr_ok && aw_addr_reg == CTMR_OFS_FLAGS && w_data_reg[CTMR_POS_FLAG_P])
        flag_p_reg <= 1'b0;
    end
  end

  // compare-mode output state
  always_comb
  begin
    out_next = out_reg;
    if (on_rise)
      out_next = oc_reg;
    else if (mode_reg == CTMR_MODE_CMP && match_a)
    begin
      case (io_reg)
        2'h1: out_next = 1'b0;
        2'h2: out_next = 1'b1;
        2'h3: out_next = ~out_reg;
        default: out_next = out_reg;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      out_reg <= 1'b0;
    else
      out_reg <= out_next;
  end

  // pwm: duty from A or from P scaled by 256, P of zero meaning full 65536
  always_comb
  begin
    if (dpx_reg)
      duty_val = (cmp_p_reg == CTMR_RST_BYTE) ? 17'h10000 : {1'b0, cmp_p_reg, 8'h00};
    else
      duty_val = {1'b0, cmp_a_reg};
    pwm_on = {1'b0, cnt_reg} < duty_val;
  end

  always_comb
  begin
    pin_used = (mode_reg == CTMR_MODE_CMP) || (mode_reg == CTMR_MODE_PWM);
    case (mode_reg)
      CTMR_MODE_CMP: level_c = out_reg;
      CTMR_MODE_PWM:
      begin
        case (io_reg)
          2'h1: level_c = oc_reg;
          2'h2: level_c = pwm_on ? oc_reg : ~oc_reg;
          default: level_c = ~oc_reg;
        endcase
      end
      default: level_c = 1'b0;
    endcase
  end

  // pin is registered, so it follows the internal level by one cycle
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      pin_reg <= 1'b0;
    else
      pin_reg <= pin_used ? (level_c ^ pol_reg) : 1'b0;
  end

  assign TIMER_OUT = pin_reg;
  assign TIMER_OUT_USED = pin_used;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n_reg);

  pause_holds_a: assert property (pause_reg && !on_rise |=> cnt_reg == $past(cnt_reg))
    else $error("count moved while paused");
  on_clears_a: assert property (on_rise |=> cnt_reg == 16'h0000)
    else $error("count not cleared on enable");
  off_holds_a: assert property (!on_reg ##1 !on_reg |-> $stable(cnt_reg))
    else $error("count moved while off");
  low_bits_a: assert property (rvalid_reg && rd_addr_reg == CTMR_OFS_CTRL_A
    |-> rdata_reg[2:0] == 3'h0)
    else $error("control A low bits not zero");
  sys_count_a: assert property (on_reg && !pause_reg && !on_rise
    && cksel_reg == CTMR_CK_SYS && !clear_now |=> cnt_reg == $past(cnt_inc))
    else $error("count did not step on system clock");
  init_level_a: assert property (on_rise && mode_reg == CTMR_MODE_CMP
    |=> out_reg == $past(oc_reg) ##1 pin_reg == ($past(oc_reg, 2) ^ $past(pol_reg)))
    else $error("pin not at initial level");
  toggle_act_a: assert property (mode_reg == CTMR_MODE_CMP && match_a && !on_rise
    && io_reg == 2'h3 |=> out_reg != $past(out_reg))
    else $error("toggle missed");
  no_pflag_a: assert property (mode_reg == CTMR_MODE_CMP && cclr_reg && !flag_p_reg
    |=> !flag_p_reg)
    else $error("compare P flag set with A clearing");
  pwm_force_a: assert property (mode_reg == CTMR_MODE_PWM && io_reg == 2'h0
    ##1 $stable(pol_reg) && $stable(oc_reg) |-> pin_reg == (~oc_reg ^ pol_reg))
    else $error("forced inactive level wrong");
  tmr_pin_a: assert property (mode_reg == CTMR_MODE_TMR |=> !pin_reg)
    else $error("pin driven in timer mode");
  p_clear_a: assert property (match_p && !clr_by_a && !on_rise |=> cnt_reg == 16'h0000)
    else $error("P match did not clear");

  pause_seen_c: cover property (on_reg && pause_reg ##1 !pause_reg);
  a_match_c: cover property (mode_reg == CTMR_MODE_CMP && match_a);
  pwm_wave_c: cover property (mode_reg == CTMR_MODE_PWM && io_reg == 2'h2 && pwm_on);
  overflow_c: cover property (match_p && cmp_p_reg == 8'h00);
endmodule

// ### core/ctmr_pkg.sv
// compact timer package: register map, field layout, reset values, modes
package ctmr_pkg;
  localparam logic [7:0] CTMR_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] CTMR_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] CTMR_OFS_CNT_LO = 8'h08;
  localparam logic [7:0] CTMR_OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] CTMR_OFS_CMPA_LO = 8'h10;
  localparam logic [7:0] CTMR_OFS_CMPA_HI = 8'h14;
  localparam logic [7:0] CTMR_OFS_CMPP = 8'h18;
  localparam logic [7:0] CTMR_OFS_FLAGS = 8'h1c;
  // control A fields
  localparam int CTMR_POS_PAUSE = 7;
  localparam int CTMR_POS_CKSEL = 4;
  localparam int CTMR_POS_ON = 3;
  // control B fields
  localparam int CTMR_POS_MODE = 6;
  localparam int CTMR_POS_IO = 4;
  localparam int CTMR_POS_OC = 3;
  localparam int CTMR_POS_POL = 2;
  localparam int CTMR_POS_DPX = 1;
  localparam int CTMR_POS_CCLR = 0;
  // flags register fields
  localparam int CTMR_POS_FLAG_A = 0;
  localparam int CTMR_POS_FLAG_P = 1;
  localparam logic [7:0] CTMR_RST_BYTE = 8'h00;
  localparam logic [15:0] CTMR_RST_WORD = 16'h0000;
  localparam logic [1:0] CTMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] CTMR_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    CTMR_MODE_CMP = 2'b00,
    CTMR_MODE_UNDEF = 2'b01,
    CTMR_MODE_PWM = 2'b10,
    CTMR_MODE_TMR = 2'b11
  } ctmr_mode_t;
  typedef enum logic [2:0]
  {
    CTMR_CK_SYS4 = 3'b000,
    CTMR_CK_SYS = 3'b001,
    CTMR_CK_H16 = 3'b010,
    CTMR_CK_H64 = 3'b011,
    CTMR_CK_SUB0 = 3'b100,
    CTMR_CK_SUB1 = 3'b101,
    CTMR_CK_PINR = 3'b110,
    CTMR_CK_PINF = 3'b111
  } ctmr_cksel_t;
endpackage

// ### verif/ctmr_tb.sv
// self-checking testbench for the compact timer register block
`timescale 1ns/100ps
module testbench;
  import ctmr_pkg::*;
  // rows {mode, pin action, level, polarity, duty/period}
  localparam logic [6:0] TAB [13] = '{7'b0000000, 7'b0001000, 7'b0010100, 7'b0010000,
    7'b0001100, 7'b0010010, 7'b1000100, 7'b1001100, 7'b1001010, 7'b1011100, 7'b1010100,
    7'b1010010, 7'b1010101};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ext_pin = 1'b0;
  logic sub_clk = 1'b0;
  logic timer_out, out_used, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 clock = ~clock;

  ctmr_top ctmr_top_inst (.CLOCK(clock), .RST_N(rst_n), .EXT_COUNT_PIN(ext_pin),
    .SUB_CLOCK(sub_clk), .TIMER_OUT(timer_out), .TIMER_OUT_USED(out_used),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic hang;
    n_mismatch++;
    $display("CHECK FAILED at %0t: no bus answer", $time);
    report_and_stop();
  endtask

  // ready is looked at on the falling edge so the rising edge decides cleanly
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb)
        chk(bresp, er, "write response");
      @(posedge clock);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
      begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      if (tr)
        chk(rresp, er, "read response");
      @(posedge clock);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
      begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, CTMR_RESP_OKAY, v);
    chk(v, exp, "register value");
  endtask

  // high byte first so the low byte comes from the same snapshot
  task automatic cnt(output logic [15:0] c);
    logic [31:0] h, l;
    rd(CTMR_OFS_CNT_HI, CTMR_RESP_OKAY, h);
    rd(CTMR_OFS_CNT_LO, CTMR_RESP_OKAY, l);
    c = {h[7:0], l[7:0]};
  endtask

  // slow pulses so the pin synchroniser never misses an edge
  task automatic pulse(input logic sub, input int n);
    repeat (n)
    begin
      @(posedge clock);
      sub_clk <= sub;
      ext_pin <= !sub;
      repeat (4) @(posedge clock);
      sub_clk <= 1'b0;
      ext_pin <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask

  function automatic logic [7:0] ca(input logic p, input logic [2:0] s, input logic on);
    return {p, s, on, 3'b000};
  endfunction

  // {level shortly after start, level after a long run}
  function automatic logic [1:0] exp_out(input logic [6:0] e);
    logic ini, fin;
    if (e[6:5] == 2'b00)
    begin
      ini = e[2];
      fin = (e[4:3] == 2'b00) ? e[2] : e[4];
    end
    else
    begin
      ini = (e[4:3] == 2'b01 || e[4:3] == 2'b10) ? e[2] : !e[2];
      fin = (e[4:3] == 2'b01 || (e[4:3] == 2'b10 && e[0])) ? e[2] : !e[2];
    end
    return {ini ^ e[1], fin ^ e[1]};
  endfunction

  initial
  begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    $display("CHECK FAILED at %0t: run too long", $time);
    report_and_stop();
  end

  initial
  begin
    int q, r, dv, n;
    logic [2:0] s;
    logic [15:0] c;
    logic [31:0] v;
    logic [1:0] x;
    logic last;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i++)
      rc(8'(4 * i), 32'h0);
    wr(CTMR_OFS_CTRL_A, 8'hff, CTMR_RESP_OKAY);
    rc(CTMR_OFS_CTRL_A, 32'hf8);
    wr(CTMR_OFS_CTRL_B, 8'hff, CTMR_RESP_OKAY);
    rc(CTMR_OFS_CTRL_B, 32'hff);
    wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_B, 8'h00, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CNT_LO, 8'h55, CTMR_RESP_SLVERR);
    rd(8'h20, CTMR_RESP_SLVERR, v);
    chk(v, 32'h0, "unmapped read");
    cnt(c);
    chk(c, 16'h0000, "count after refused write");
    wr(CTMR_OFS_CMPA_LO, 8'h34, CTMR_RESP_OKAY);
    rc(CTMR_OFS_CMPA_HI, 32'h00);
    rc(CTMR_OFS_CMPA_LO, 32'h00);
    // the high read reloaded the shared buffer, so refill it
    wr(CTMR_OFS_CMPA_LO, 8'h34, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CMPA_HI, 8'h12, CTMR_RESP_OKAY);
    rc(CTMR_OFS_CMPA_HI, 32'h12);
    rc(CTMR_OFS_CMPA_LO, 32'h34);
    for (int i = 0; i < 4; i++)
    begin
      s = 3'(i < 2 ? 6 + i : 2 + i);
      wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
      wr(CTMR_OFS_CTRL_A, ca(1'b0, s, 1'b1), CTMR_RESP_OKAY);
      pulse(s[2:1] == 2'b10, 5);
      cnt(c);
      chk(c, 16'd5, "pin edge count");
    end
    wr(CTMR_OFS_CTRL_A, ca(1'b1, s, 1'b1), CTMR_RESP_OKAY);
    pulse(1'b1, 3);
    cnt(c);
    chk(c, 16'd5, "paused count");
    wr(CTMR_OFS_CTRL_A, ca(1'b0, s, 1'b1), CTMR_RESP_OKAY);
    pulse(1'b1, 2);
    cnt(c);
    chk(c, 16'd7, "resumed count");
    wr(CTMR_OFS_CTRL_A, ca(1'b0, s, 1'b0), CTMR_RESP_OKAY);
    pulse(1'b1, 2);
    cnt(c);
    chk(c, 16'd7, "residual count");
    wr(CTMR_OFS_CTRL_A, ca(1'b0, s, 1'b1), CTMR_RESP_OKAY);
    cnt(c);
    chk(c, 16'd0, "count cleared on start");
    for (int i = 0; i < 4; i++)
    begin
      s = 3'(i < 2 ? 1 - i : i);
      dv = (i == 0) ? 1 : 1 << (2 * i);
      wr(CTMR_OFS_CTRL_A, ca(1'b1, s, 1'b1), CTMR_RESP_OKAY);
      wr(CTMR_OFS_CTRL_A, ca(1'b0, s, 1'b1), CTMR_RESP_OKAY);
      repeat (640) @(posedge clock);
      wr(CTMR_OFS_CTRL_A, ca(1'b1, s, 1'b1), CTMR_RESP_OKAY);
      cnt(c);
      q = int'(c) * dv;
      if (i == 0)
        r = q;
      chk(q + dv + 8 > r && r + dv + 8 > q, 1'b1, "prescaler ratio");
      wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
    end
    wr(CTMR_OFS_CMPA_LO, 8'h10, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CMPA_HI, 8'h00, CTMR_RESP_OKAY);
    for (int i = 0; i < 13; i++)
    begin
      x = exp_out(TAB[i]);
      wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
      wr(CTMR_OFS_CTRL_B, {TAB[i], 1'b1}, CTMR_RESP_OKAY);
      wr(CTMR_OFS_CTRL_A, ca(1'b0, 3'b001, 1'b1), CTMR_RESP_OKAY);
      repeat (3) @(negedge clock);
      chk(out_used, 1'b1, "pin in use");
      chk(timer_out, x[1], "start level");
      repeat (100) @(negedge clock);
      chk(timer_out, x[0], "run level");
    end
    wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
    for (int m = 1; m < 4; m += 2)
    begin
      wr(CTMR_OFS_CTRL_B, {2'(m), 6'h00}, CTMR_RESP_OKAY);
      chk(out_used, 1'b0, "pin unused in timer mode");
    end
    wr(CTMR_OFS_CTRL_B, 8'h31, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_A, ca(1'b0, 3'b001, 1'b1), CTMR_RESP_OKAY);
    n = 0;
    last = timer_out;
    repeat (200)
    begin
      @(negedge clock);
      if (timer_out !== last)
        n++;
      last = timer_out;
    end
    chk(n >= 8, 1'b1, "toggle count");
    wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_B, 8'hc0, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CMPP, 8'h01, CTMR_RESP_OKAY);
    wr(CTMR_OFS_FLAGS, 8'h03, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_A, ca(1'b0, 3'b001, 1'b1), CTMR_RESP_OKAY);
    repeat (300) @(posedge clock);
    rd(CTMR_OFS_FLAGS, CTMR_RESP_OKAY, v);
    chk(v[1], 1'b1, "period flag");
    cnt(c);
    chk(c[15:8], 8'h00, "cleared by period match");
    wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_B, 8'h01, CTMR_RESP_OKAY);
    wr(CTMR_OFS_FLAGS, 8'h03, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_A, ca(1'b0, 3'b001, 1'b1), CTMR_RESP_OKAY);
    repeat (300) @(posedge clock);
    rc(CTMR_OFS_FLAGS, 32'h01);
    wr(CTMR_OFS_CTRL_A, 8'h00, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CMPP, 8'h00, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_B, 8'hc0, CTMR_RESP_OKAY);
    wr(CTMR_OFS_FLAGS, 8'h03, CTMR_RESP_OKAY);
    wr(CTMR_OFS_CTRL_A, ca(1'b0, 3'b001, 1'b1), CTMR_RESP_OKAY);
    repeat (65600) @(posedge clock);
    rd(CTMR_OFS_FLAGS, CTMR_RESP_OKAY, v);
    chk(v[1], 1'b1, "overflow flag");
    cnt(c);
    chk(c[15:8], 8'h00, "wrapped count");
    report_and_stop();
  end
endmodule
